// ---- core/cws_pin_mux.sv ----
// file: one select-coded pin multiplexer per output pin
`timescale 1ns/100ps
`default_nettype none
module cws_pin_mux #(
  parameter int PINS = 6
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] phase_in,
  input wire logic [3*PINS-1:0] sel_in,
  output logic [PINS-1:0] pin_out
);
  logic [PINS-1:0] pin_d;
  logic [PINS-1:0] pin_q;

  // decode one 3-bit code; undefined codes give a low level
  function automatic logic route(input logic [2:0] sel,
                                 input logic [2:0] ph);
    case (sel)
      cws_pkg::SEL_PH1: route = ph[0];
      cws_pkg::SEL_PH2: route = ph[1];
      cws_pkg::SEL_PH3: route = ph[2];
      cws_pkg::SEL_ONE: route = 1'b1;
      cws_pkg::SEL_ZERO: route = 1'b0;
      default: route = 1'b0;
    endcase
  endfunction

  // one independent mux per pin
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_comb begin
        pin_d[g] = route(sel_in[3*g +: 3], phase_in); // [RULE11] [RULE13]
      end
    end
  endgenerate

  // registered so all pins move on one edge, one bit per switch
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d; // [RULE1] [RULE17]
    end
  end
  assign pin_out = pin_q;
endmodule
`default_nettype wire

// ---- core/cws_sequencer.sv ----
// file: top of the ccd clock waveform sequencer with apb registers
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: each clock output is one digital bit choosing one of two levels
// RULE2: three 8-bit pattern registers: serial, video, parallel
// RULE3: pattern registers load byte by byte from table memory
// RULE4: serial byte bits 0-4: phases one-three, reset gate, well gate
// RULE5: serial byte bits 5-7 affect no output
// RULE6: video byte bits 0-7 are clamp through spare marker
// RULE7: parallel byte: image phases, store phases, transfer gate, spare
// RULE8: serial and video bytes always update in the same step
// RULE9: table author supplies one video byte per serial byte
// RULE10: six serial pins each with its own mux from three phases
// RULE11: serial select codes 1-3 phases, 4 forces one, 5 forces zero
// RULE12: parallel pins: three image pins and three store pins
// RULE13: parallel select codes 1-3 group phases, 4 one, 5 zero
// RULE14: table entries read strictly ascending, no loops or branches
// RULE15: binning needs a duplicated waveform per factor 1,2,4,8
// RULE16: six serial waveforms each start at a fixed paired address
// RULE17: one entry per clock, all patterns updated on one edge
// RULE18: idle patterns held after reset and when nothing runs
module cws_sequencer (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [5:0] serial_pins_out,
  output logic [5:0] parallel_pins_out,
  output logic reset_gate_out,
  output logic well_gate_out,
  output logic transfer_gate_bit_out,
  output logic [7:0] video_ctrl_out,
  output logic busy_out
);
  // ****************************************************************
  // state
  // ****************************************************************
  cws_pkg::cws_state_e state_q, state_d;
  logic [12:0] ser_addr_q, ser_addr_d;
  logic [12:0] par_addr_q, par_addr_d;
  logic [12:0] left_q, left_d;
  logic par_mode_q, par_mode_d;
  logic fetch_q, fetch_d;
  logic [7:0] ser_q, ser_d;
  logic [7:0] vid_q, vid_d;
  logic [7:0] par_q, par_d;
  logic [17:0] smux_q, smux_d;
  logic [17:0] pmux_q, pmux_d;
  logic [12:0] len_q, len_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] ser_rd, vid_rd, par_rd;
  logic wr_acc, rd_acc, start, stop;
  logic [2:0] wave_sel;
  cws_pkg::cws_serial_s ser_view;
  cws_pkg::cws_parallel_s par_view;

  // fixed start entry per serial waveform; video uses the same index
  function automatic logic [12:0] wave_base(input logic [2:0] sel);
    case (sel)
      3'h0: wave_base = cws_pkg::SER_BASE_UNBINNED_PATTERN;
      3'h1: wave_base = cws_pkg::SER_BASE_BIN2;
      3'h2: wave_base = cws_pkg::SER_BASE_BIN4;
      3'h3: wave_base = cws_pkg::SER_BASE_BIN8;
      3'h4: wave_base = cws_pkg::SER_BASE_IDLE;
      3'h5: wave_base = cws_pkg::SER_BASE_SKIP;
      default: wave_base = cws_pkg::SER_BASE_IDLE;
    endcase
  endfunction

  // ****************************************************************
  // apb decode: zero wait state, unmapped reads zero, slverr only above ADDR_LEN
  // ****************************************************************
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign start = wr_acc && (paddr == cws_pkg::ADDR_CTRL)
                 && pwdata[cws_pkg::CTRL_START_BIT];
  assign stop = wr_acc && (paddr == cws_pkg::ADDR_CTRL)
                && pwdata[cws_pkg::CTRL_STOP_BIT];
  assign wave_sel = pwdata[cws_pkg::CTRL_SEL_LSB +: 3];

  // ****************************************************************
  // table memories: serial, video and parallel
  // ****************************************************************
  cws_table_mem #(.AW(cws_pkg::TBL_AW)) u_ser_mem (
    .core_clk_in(core_clk_in),
    .wr_en_in(wr_acc && paddr == cws_pkg::ADDR_TBL_SER),
    .wr_addr_in(pwdata[20:8]),
    .wr_data_in(pwdata[7:0]),
    .rd_addr_in(ser_addr_q),
    .rd_data_out(ser_rd)
  );
  cws_table_mem #(.AW(cws_pkg::TBL_AW)) u_vid_mem (
    .core_clk_in(core_clk_in),
    .wr_en_in(wr_acc && paddr == cws_pkg::ADDR_TBL_VID),
    .wr_addr_in(pwdata[20:8]),
    .wr_data_in(pwdata[7:0]),
    .rd_addr_in(ser_addr_q),
    .rd_data_out(vid_rd)
  );
  cws_table_mem #(.AW(cws_pkg::TBL_AW)) u_par_mem (
    .core_clk_in(core_clk_in),
    .wr_en_in(wr_acc && paddr == cws_pkg::ADDR_TBL_PAR),
    .wr_addr_in(pwdata[20:8]),
    .wr_data_in(pwdata[7:0]),
    .rd_addr_in(par_addr_q),
    .rd_data_out(par_rd)
  );

  // ****************************************************************
  // sequencer next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    ser_addr_d = ser_addr_q;
    par_addr_d = par_addr_q;
    left_d = left_q;
    par_mode_d = par_mode_q;
    fetch_d = 1'b0;
    ser_d = ser_q;
    vid_d = vid_q;
    par_d = par_q;
    case (state_q)
      cws_pkg::ST_IDLE: begin
        // hold idle levels so the switches sit static [RULE18]
        ser_d = cws_pkg::SER_IDLE;
        vid_d = cws_pkg::VID_IDLE;
        par_d = cws_pkg::PAR_IDLE;
        if (start) begin
          par_mode_d = pwdata[cws_pkg::CTRL_PAR_BIT];
          ser_addr_d = wave_base(wave_sel); // [RULE16]
          par_addr_d = cws_pkg::PAR_BASE;
          left_d = len_q;
          state_d = cws_pkg::ST_RUN;
        end
      end
      cws_pkg::ST_RUN: begin
        // memory answers one cycle after the address; skip that cycle
        fetch_d = 1'b1;
        if (fetch_q) begin
          if (par_mode_q) begin
            par_d = par_rd; // [RULE3]
          end else begin
            ser_d = ser_rd; // [RULE3] [RULE8]
            vid_d = vid_rd; // [RULE8]
          end
        end
        // strictly ascending, one entry per clock, no branch [RULE14]
        ser_addr_d = ser_addr_q + 13'h0001; // [RULE17]
        par_addr_d = par_addr_q + 13'h0001;
        if (fetch_q) begin
          left_d = left_q - 13'h0001;
        end
        if (stop || (fetch_q && left_q == 13'h0001)) begin
          state_d = cws_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = cws_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= cws_pkg::ST_IDLE;
      ser_addr_q <= '0;
      par_addr_q <= '0;
      left_q <= '0;
      par_mode_q <= 1'b0;
      fetch_q <= 1'b0;
      ser_q <= cws_pkg::SER_IDLE; // [RULE18]
      vid_q <= cws_pkg::VID_IDLE;
      par_q <= cws_pkg::PAR_IDLE;
    end else begin
      state_q <= state_d;
      ser_addr_q <= ser_addr_d;
      par_addr_q <= par_addr_d;
      left_q <= left_d;
      par_mode_q <= par_mode_d;
      fetch_q <= fetch_d;
      ser_q <= ser_d; // [RULE2]
      vid_q <= vid_d; // [RULE2]
      par_q <= par_d; // [RULE2]
    end
  end

  // ****************************************************************
  // configuration registers and read data
  // ****************************************************************
  always_comb begin
    smux_d = smux_q;
    pmux_d = pmux_q;
    len_d = len_q;
    if (wr_acc && paddr == cws_pkg::ADDR_SMUX) begin
      smux_d = pwdata[17:0];
    end
    if (wr_acc && paddr == cws_pkg::ADDR_PMUX) begin
      pmux_d = pwdata[17:0];
    end
    if (wr_acc && paddr == cws_pkg::ADDR_LEN && pwdata[12:0] != '0) begin
      len_d = pwdata[12:0];
    end
    rdata_d = 32'h0000_0000;
    case (paddr)
      cws_pkg::ADDR_CTRL: rdata_d = {31'h0, par_mode_q};
      cws_pkg::ADDR_STATUS: rdata_d = {19'h0, left_q};
      cws_pkg::ADDR_SMUX: rdata_d = {14'h0, smux_q};
      cws_pkg::ADDR_PMUX: rdata_d = {14'h0, pmux_q};
      cws_pkg::ADDR_PATTERN: rdata_d = {7'h0, busy_out, par_q, vid_q, ser_q};
      cws_pkg::ADDR_LEN: rdata_d = {19'h0, len_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      smux_q <= cws_pkg::SMUX_RST;
      pmux_q <= cws_pkg::PMUX_RST;
      len_q <= cws_pkg::LEN_RST;
    end else begin
      smux_q <= smux_d;
      pmux_q <= pmux_d;
      len_q <= len_d;
    end
  end
  assign rdata_q = rdata_d;
  assign prdata = rd_acc ? rdata_q : 32'h0000_0000;
  assign pslverr = psel && penable && (paddr > cws_pkg::ADDR_LEN);

  // ****************************************************************
  // bit decode and pin routing
  // ****************************************************************
  // bits 5-7 of the serial byte are folded away and reach no pin
  assign ser_view = {1'b0, ser_q[4:0]}; // [RULE4] [RULE5]
  assign par_view = par_q[6:0]; // [RULE7]

  cws_pin_mux #(.PINS(6)) u_ser_mux (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .phase_in({ser_view.serial_phase_three, ser_view.serial_phase_two,
               ser_view.serial_phase_one}),
    .sel_in(smux_q),
    .pin_out(serial_pins_out) // [RULE10]
  );
  cws_pin_mux #(.PINS(3)) u_img_mux (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .phase_in(par_view.image_phase),
    .sel_in(pmux_q[8:0]),
    .pin_out(parallel_pins_out[2:0]) // [RULE12]
  );
  cws_pin_mux #(.PINS(3)) u_sto_mux (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .phase_in(par_view.store_phase),
    .sel_in(pmux_q[17:9]),
    .pin_out(parallel_pins_out[5:3]) // [RULE12]
  );

  // gate bits are delayed one flop to line up with the muxed pins
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_gate_out <= 1'b0;
      well_gate_out <= 1'b0;
      transfer_gate_bit_out <= 1'b0;
      video_ctrl_out <= cws_pkg::VID_IDLE;
    end else begin
      reset_gate_out <= ser_view.reset_gate; // [RULE4]
      well_gate_out <= ser_view.well_gate; // [RULE4]
      transfer_gate_bit_out <= par_view.transfer_gate_bit; // [RULE7]
      video_ctrl_out <= vid_q; // [RULE6] [RULE8]
    end
  end
  assign busy_out = (state_q == cws_pkg::ST_RUN);
endmodule
`default_nettype wire

// ---- core/cws_table_mem.sv ----
// file: waveform table memory, apb write port, sequencer read port
`timescale 1ns/100ps
`default_nettype none
module cws_table_mem #(
  parameter int AW = 13
) (
  input wire logic core_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [0:(1<<AW)-1];

  // synchronous read, one cycle latency; no reset on storage
  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule
`default_nettype wire

// ---- include/cws_pkg.sv ----
// package: constants and carriers for the clock waveform sequencer
package cws_pkg;
  // ****************************************************************
  // apb register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SMUX = 12'h008;
  localparam logic [11:0] ADDR_PMUX = 12'h00C;
  localparam logic [11:0] ADDR_PATTERN = 12'h010;
  localparam logic [11:0] ADDR_TBL_SER = 12'h014;
  localparam logic [11:0] ADDR_TBL_VID = 12'h018;
  localparam logic [11:0] ADDR_TBL_PAR = 12'h01C;
  localparam logic [11:0] ADDR_LEN = 12'h020;
  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_PAR_BIT = 8;
  localparam int CTRL_STOP_BIT = 1;
  // ****************************************************************
  // waveform start entries (table indices), six serial waveforms
  // ****************************************************************
  localparam int WAVE_COUNT = 6;
  localparam int TBL_AW = 13;
  localparam logic [12:0] SER_BASE_UNBINNED_PATTERN = 13'h0000;
  localparam logic [12:0] SER_BASE_BIN2 = 13'h0100;
  localparam logic [12:0] SER_BASE_BIN4 = 13'h0200;
  localparam logic [12:0] SER_BASE_BIN8 = 13'h0300;
  localparam logic [12:0] SER_BASE_IDLE = 13'h1000;
  localparam logic [12:0] SER_BASE_SKIP = 13'h1100;
  localparam logic [12:0] PAR_BASE = 13'h0000;
  // ****************************************************************
  // select codes and reset values: idle patterns, mux selects, run length
  // ****************************************************************
  localparam logic [7:0] SER_IDLE = 8'h00;
  localparam logic [7:0] VID_IDLE = 8'h00;
  localparam logic [7:0] PAR_IDLE = 8'h00;
  localparam logic [2:0] SEL_PH1 = 3'h1;
  localparam logic [2:0] SEL_PH2 = 3'h2;
  localparam logic [2:0] SEL_PH3 = 3'h3;
  localparam logic [2:0] SEL_ONE = 3'h4;
  localparam logic [2:0] SEL_ZERO = 3'h5;
  localparam logic [17:0] SMUX_RST = 18'h0A4D1;
  localparam logic [17:0] PMUX_RST = 18'h0D1D1;
  localparam logic [12:0] LEN_RST = 13'h0010;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic unused_bits;
    logic well_gate;
    logic reset_gate;
    logic serial_phase_three;
    logic serial_phase_two;
    logic serial_phase_one;
  } cws_serial_s;
  typedef struct packed {
    logic spare_marker;
    logic clamp_sample_start;
    logic convert_start;
    logic dc_restore;
    logic polarity_inv;
    logic polarity;
    logic sample;
    logic clamp;
  } cws_video_s;
  typedef struct packed {
    logic transfer_gate_bit;
    logic [2:0] store_phase;
    logic [2:0] image_phase;
  } cws_parallel_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } cws_state_e;
endpackage

// ---- testbench/cws_checker.sv ----
// checker: port-level properties of the clock waveform sequencer
`timescale 1ns/100ps
`default_nettype none
module cws_checker (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] serial_pins_out,
  input wire logic [5:0] parallel_pins_out,
  input wire logic reset_gate_out,
  input wire logic well_gate_out,
  input wire logic transfer_gate_bit_out,
  input wire logic [7:0] video_ctrl_out,
  input wire logic busy_out
);
  // ****
  // shadow copies of the pin selects
  // ****
  logic [17:0] smux_q, smux_d, pmux_q, pmux_d;
  logic [5:0] s_one, s_zero, p_one, p_zero;
  logic wr;
  assign wr = psel && penable && pwrite;
  // follow apb writes so forced pins can be predicted
  always_comb begin
    smux_d = smux_q;
    pmux_d = pmux_q;
    if (wr && paddr == cws_pkg::ADDR_SMUX) smux_d = pwdata[17:0];
    if (wr && paddr == cws_pkg::ADDR_PMUX) pmux_d = pwdata[17:0];
  end
  // shadow registers
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      smux_q <= cws_pkg::SMUX_RST;
      pmux_q <= cws_pkg::PMUX_RST;
    end else begin
      smux_q <= smux_d;
      pmux_q <= pmux_d;
    end
  end
  // per-pin force masks; phase codes cannot be seen from outside
  for (genvar i = 0; i < 6; i++) begin : g_sel
    assign s_one[i] = smux_q[3*i +: 3] == cws_pkg::SEL_ONE;
    assign s_zero[i] = smux_q[3*i +: 3] == cws_pkg::SEL_ZERO;
    assign p_one[i] = pmux_q[3*i +: 3] == cws_pkg::SEL_ONE;
    assign p_zero[i] = pmux_q[3*i +: 3] == cws_pkg::SEL_ZERO;
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_ser_one;
    $stable(s_one) |-> (serial_pins_out & s_one) == s_one;
  endproperty
  a_ser_one: assert property (p_ser_one)
    else $error("serial pin not forced high");
  property p_ser_zero;
    $stable(s_zero) |-> (serial_pins_out & s_zero) == 6'h00;
  endproperty
  a_ser_zero: assert property (p_ser_zero)
    else $error("serial pin not forced low");
  property p_par_one;
    $stable(p_one) |-> (parallel_pins_out & p_one) == p_one;
  endproperty
  a_par_one: assert property (p_par_one)
    else $error("parallel pin not forced high");
  property p_par_zero;
    $stable(p_zero) |-> (parallel_pins_out & p_zero) == 6'h00;
  endproperty
  a_par_zero: assert property (p_par_zero)
    else $error("parallel pin not forced low");
  property p_idle;
    !busy_out [*3] |-> video_ctrl_out == 8'h00 && !reset_gate_out &&
      !well_gate_out && !transfer_gate_bit_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pattern not idle while stopped");
  property p_change;
    $changed(video_ctrl_out) |->
      $past(busy_out) || $past(busy_out, 2) || $past(busy_out, 3);
  endproperty
  a_change: assert property (p_change)
    else $error("video byte moved with no waveform running");
  property p_start;
    wr && paddr == cws_pkg::ADDR_CTRL && pwdata[0] && !pwdata[1] &&
      !busy_out |=> busy_out;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not raise busy");
  property p_apb;
    psel && penable |-> pready && pslverr == (paddr > 12'h020);
  endproperty
  a_apb: assert property (p_apb)
    else $error("apb answer wrong");
endmodule
`default_nettype wire

// ---- testbench/cws_sequencer_tb_top.sv ----
// bench: apb-driven run of every waveform through the sequencer
`timescale 1ns/100ps
`default_nettype none
module cws_sequencer_tb_top;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, reset_gate_out, well_gate_out;
  logic transfer_gate_bit_out, busy_out;
  logic [5:0] serial_pins_out, parallel_pins_out;
  logic [7:0] video_ctrl_out;
  logic [11:0][15:0] level;
  int miscompares = 0;
  int checks = 0;
  localparam int LEN = 3;
  localparam logic [17:0] SMUX = 18'h058D1; // codes 1,2,3,4,5,0
  localparam logic [17:0] PMUX = 18'h0D88B; // codes 3,1,2,4,5,1
  logic [12:0] base [6] = '{cws_pkg::SER_BASE_UNBINNED_PATTERN,
    cws_pkg::SER_BASE_BIN2, cws_pkg::SER_BASE_BIN4,
    cws_pkg::SER_BASE_BIN8, cws_pkg::SER_BASE_IDLE,
    cws_pkg::SER_BASE_SKIP};
  cws_sequencer i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_pins_out(serial_pins_out), .parallel_pins_out(parallel_pins_out),
    .reset_gate_out(reset_gate_out), .well_gate_out(well_gate_out),
    .transfer_gate_bit_out(transfer_gate_bit_out),
    .video_ctrl_out(video_ctrl_out), .busy_out(busy_out));
  cws_switch_model i_sw (.serial_pins_in(serial_pins_out),
    .parallel_pins_in(parallel_pins_out), .level_out(level));
  // 200 mhz core clock
  always #2.5 core_clk_in = ~core_clk_in;
  // pin select as the rules define the codes
  function automatic logic sel(input logic [2:0] c, input logic [2:0] ph);
    case (c)
      3'h1: return ph[0];
      3'h2: return ph[1];
      3'h3: return ph[2];
      3'h4: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [5:0] pins(input logic [17:0] s,
    input logic [2:0] a, input logic [2:0] b);
    for (int i = 0; i < 6; i++) pins[i] = sel(s[3*i +: 3], i < 3 ? a : b);
  endfunction
  // table bytes; upper serial bits set so they must be ignored
  function automatic logic [7:0] serb(input int w, input int k);
    return 8'hE0 | 8'(w * 5 + k * 7 + 3);
  endfunction
  function automatic logic [7:0] vidb(input int w, input int k);
    return 8'(w * 16 + k + 17);
  endfunction
  function automatic logic [7:0] parb(input int k);
    return 8'(k * 43 + 149);
  endfunction
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, then one idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // start one waveform and follow it entry by entry
  task automatic run(input int w, input logic par);
    logic [7:0] b;
    logic [5:0] ep;
    wr(cws_pkg::ADDR_CTRL, {23'h0, par, 1'b0, 3'(w), 4'h1});
    #1;
    chk("busy", 32'h1, 32'(busy_out));
    @(posedge core_clk_in);
    // muxed pins and gate flops share one output stage: same entry each edge
    for (int j = 0; j < LEN; j++) begin
      @(posedge core_clk_in);
      #1;
      b = par ? parb(j) : serb(w, j);
      ep = par ? pins(PMUX, b[2:0], b[5:3]) : pins(SMUX, b[2:0], b[2:0]);
      if (par) begin
        chk("tgate", 32'(b[6]), 32'(transfer_gate_bit_out));
        chk("ppins", 32'(ep), 32'(parallel_pins_out));
      end else begin
        chk("video", 32'(vidb(w, j)), 32'(video_ctrl_out));
        chk("rgate", 32'(b[3]), 32'(reset_gate_out));
        chk("well", 32'(b[4]), 32'(well_gate_out));
        chk("spins", 32'(ep), 32'(serial_pins_out));
      end
    end
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("busy", 32'h0, 32'(busy_out));
    chk("video", 32'h0, 32'(video_ctrl_out));
    chk("spins", 32'(pins(SMUX, 3'h0, 3'h0)), 32'(serial_pins_out));
    chk("ppins", 32'(pins(PMUX, 3'h0, 3'h0)), 32'(parallel_pins_out));
    chk("level", 32'(16'h1000), 32'(level[3]));
    @(posedge core_clk_in);
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    chk("busy", 32'h0, 32'(busy_out));
    chk("video", 32'h0, 32'(video_ctrl_out));
    @(posedge core_clk_in);
    apb(1'b0, cws_pkg::ADDR_SMUX, 32'h0, r, e);
    chk("smux", 32'(cws_pkg::SMUX_RST), r);
    apb(1'b0, cws_pkg::ADDR_LEN, 32'h0, r, e);
    chk("len", 32'(cws_pkg::LEN_RST), r);
    apb(1'b0, 12'h024, 32'h0, r, e);
    chk("slverr", 32'h1, 32'(e));
    chk("errdata", 32'h0, r);
    wr(cws_pkg::ADDR_LEN, 32'(LEN));
    wr(cws_pkg::ADDR_SMUX, 32'(SMUX));
    wr(cws_pkg::ADDR_PMUX, 32'(PMUX));
    // one video byte per serial byte, same index
    // each binning factor gets a table section of its own
    for (int w = 0; w < 6; w++) begin
      for (int k = 0; k < LEN; k++) begin
        wr(cws_pkg::ADDR_TBL_SER, {11'h0, base[w] + 13'(k), serb(w, k)});
        wr(cws_pkg::ADDR_TBL_VID, {11'h0, base[w] + 13'(k), vidb(w, k)});
      end
    end
    for (int k = 0; k < LEN; k++) begin
      wr(cws_pkg::ADDR_TBL_PAR, {11'h0, cws_pkg::PAR_BASE + 13'(k), parb(k)});
    end
    for (int w = 0; w < 6; w++) run(w, 1'b0);
    run(0, 1'b1);
    // stop bit drops a running waveform back to the idle levels
    wr(cws_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(cws_pkg::ADDR_CTRL, 32'h0000_0002);
    #1;
    chk("busy", 32'h0, 32'(busy_out));
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("video", 32'h0, 32'(video_ctrl_out));
    @(posedge core_clk_in);
    close_out();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge core_clk_in);
    miscompares++;
    close_out();
  end
endmodule
bind cws_sequencer cws_checker i_chk (.core_clk_in(core_clk_in),
  .rst_b_in(rst_b_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_pins_out(serial_pins_out),
  .parallel_pins_out(parallel_pins_out), .reset_gate_out(reset_gate_out),
  .well_gate_out(well_gate_out),
  .transfer_gate_bit_out(transfer_gate_bit_out),
  .video_ctrl_out(video_ctrl_out), .busy_out(busy_out));
`default_nettype wire

// ---- testbench/cws_switch_model.sv ----
// partner: two-level clock switches behind the pins
`timescale 1ns/100ps
`default_nettype none
module cws_switch_model #(
  parameter logic [15:0] HI_MV = 16'h1000,
  parameter logic [15:0] LO_MV = 16'h0100
) (
  input wire logic [5:0] serial_pins_in,
  input wire logic [5:0] parallel_pins_in,
  output logic [11:0][15:0] level_out
);
  logic [11:0] bits;
  assign bits = {parallel_pins_in, serial_pins_in};
  // one bit picks one of two rails, never anything between
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      level_out[i] = bits[i] ? HI_MV : LO_MV;
    end
  end
endmodule
`default_nettype wire
